// ---- bench/osc_ctrl_chk.sv ----
// Checker: port assertions for the oscillator control block
`timescale 1ns/1ps
module osc_ctrl_chk #(
   parameter int unsigned PRESC_W = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // Outputs watched
   input wire osc_ctrl_pkg::clk_cfg_t clk_cfg,
   input wire osc_ctrl_pkg::osc_steer_t osc_steer,
   input wire logic prescaler_init,
   input wire logic main_clk_en
);
   import osc_ctrl_pkg::*;
   logic wr_q;
   logic dp_q;
   logic armed_q;
   // Key tracking mirrors the bus: any completed transfer other than the key disarms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         dp_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (hready) begin
         if (dp_q) armed_q <= wr_q && hwdata[7:0] == KEY_PATTERN;
         dp_q <= hsel && htrans[1];
         wr_q <= hsel && htrans[1] && hwrite && haddr[11:2] == 10'h000;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence keyed_s;
      wr_q && hready && armed_q && hwdata[7:3] == 5'h00;
   endsequence
   sequence plain_s;
      wr_q && hready && !armed_q;
   endsequence
   main_osc_a: assert property (osc_steer.main_osc_enable != clk_cfg.main_ext)
      else $error("main oscillator enable wrong");
   main_wait_a: assert property (osc_steer.main_stop_wdt_wait != clk_cfg.main_ext)
      else $error("main stop wait wrong");
   sub_pin_a: assert property (osc_steer.sub_oscillator_shared_pin_gpio == clk_cfg.sub_ext
      && osc_steer.sub_osc_enable != clk_cfg.sub_ext)
      else $error("sub pin or enable wrong");
   sub_wait_a: assert property (osc_steer.sub_stop_wdt_wait != clk_cfg.sub_ext)
      else $error("sub stop wait wrong");
   div_pass_a: assert property ((clk_cfg.div_bypass && !prescaler_init)[*3] |-> main_clk_en)
      else $error("undivided enable missing");
   div_half_a: assert property ((!clk_cfg.div_bypass && !prescaler_init)[*4]
      |-> main_clk_en != $past(main_clk_en))
      else $error("halved enable not alternating");
   presc_fire_a: assert property (plain_s ##0 hwdata[7] |=> prescaler_init)
      else $error("prescaler init missing");
   presc_cause_a: assert property (prescaler_init |-> $past(wr_q && hready && hwdata[7]))
      else $error("prescaler init without write");
   key_load_a: assert property (keyed_s |=> clk_cfg[2:0] == $past(hwdata[2:0])
      && clk_cfg[4:3] == 2'h0)
      else $error("keyed write not loaded");
   plain_hold_a: assert property (wr_q && hready && !(armed_q && hwdata[7:3] == 5'h00)
      |=> $stable(clk_cfg[2:0]))
      else $error("unkeyed write changed clock select");
endmodule : osc_ctrl_chk

bind osc_ctrl_top osc_ctrl_chk #(.PRESC_W(PRESC_W)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .clk_cfg(clk_cfg), .osc_steer(osc_steer), .prescaler_init(prescaler_init), .main_clk_en(main_clk_en));

// ---- bench/osc_ctrl_top_tb.sv ----
// Testbench: keyed updates, steering, prescaler and bus access
`timescale 1ns/1ps
module osc_ctrl_top_tb;
   import osc_ctrl_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, otp_part_strap, prescaler_init, main_clk_en;
   logic [31:0] haddr, hwdata, hrdata, rd, ones;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize, v;
   logic [7:0] prescaler_count;
   clk_cfg_t clk_cfg;
   osc_steer_t osc_steer;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   osc_ctrl_top #(.PRESC_W(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .otp_part_strap(otp_part_strap),
      .clk_cfg(clk_cfg), .osc_steer(osc_steer), .prescaler_init(prescaler_init),
      .main_clk_en(main_clk_en), .prescaler_count(prescaler_count));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Run is under six hundred cycles; the ceiling leaves wide margin
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Single transfer; waits on the slave, never a fixed count
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {20'h00000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic keyed(input logic [7:0] d);
      bus(1'b1, CTRL_OFFSET, KEY_PATTERN);
      bus(1'b1, CTRL_OFFSET, d);
   endtask : keyed

   task automatic do_reset(input logic strap);
      otp_part_strap <= strap;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
   endtask : do_reset

   function automatic logic [31:0] steer(input logic [2:0] c);
      return {27'h0, ~c[1], ~c[2], ~c[1], ~c[2], c[2]};
   endfunction : steer

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = HTRANS_IDLE;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      otp_part_strap = 1'b1;
      v = 3'($urandom(57));
      @(posedge hclk);
      do_reset(1'b1);
      check(32'(clk_cfg), 32'h08);
      check(32'(osc_steer), steer(3'h0));
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd & 32'hFFFFFF9F, 32'h08);
      keyed(8'h00);
      @(posedge hclk);
      check(32'(clk_cfg), 32'h00);
      for (int i = 0; i < 24; i++) begin
         v = (i < 8) ? 3'(i) : 3'($urandom);
         keyed({5'h00, v});
         repeat (3) @(posedge hclk);
         check(32'(osc_steer), steer(v));
         ones = 0;
         repeat (8) begin
            @(posedge hclk);
            ones = ones + main_clk_en;
         end
         check(ones, v[0] ? 32'h8 : 32'h4);
         bus(1'b1, CTRL_OFFSET, {5'h00, ~v});
         bus(1'b0, CTRL_OFFSET, 8'h00);
         check(rd & 32'h9F, {29'h0, v});
         check(32'(hresp), 32'(HRESP_OKAY));
      end
      keyed(8'h05);
      bus(1'b1, CTRL_OFFSET, KEY_PATTERN);
      bus(1'b0, STATUS_OFFSET, 8'h00);
      check(rd & 32'h3, 32'h1);
      bus(1'b1, CTRL_OFFSET, 8'h02);
      bus(1'b1, CTRL_OFFSET, KEY_PATTERN);
      bus(1'b1, CTRL_OFFSET, 8'h62);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd & 32'h9F, 32'h05);
      // Broken pairs leave the error flag up until software writes one to it
      bus(1'b0, STATUS_OFFSET, 8'h00);
      check(rd & 32'h3, 32'h2);
      bus(1'b1, STATUS_OFFSET, 8'h02);
      bus(1'b0, STATUS_OFFSET, 8'h00);
      check(rd & 32'h3, 32'h0);
      bus(1'b1, CTRL_OFFSET, 8'h80);
      @(posedge hclk);
      check(32'(prescaler_init), 32'h1);
      @(posedge hclk);
      check(32'(prescaler_init), 32'h0);
      check(32'(prescaler_count), 32'h00);
      bus(1'b1, 12'h010, 8'h07);
      bus(1'b0, 12'h010, 8'h00);
      check(rd, 32'h0);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd & 32'h9F, 32'h05);
      do_reset(1'b0);
      bus(1'b0, CTRL_OFFSET, 8'h00);
      check(rd & 32'hFFFFFF9F, 32'h00);
      finish_test();
   end
endmodule : osc_ctrl_top_tb

// ---- common/osc_ctrl_pkg.sv ----
// Package: offsets, field layout, reset values and types of the oscillator control block
package osc_ctrl_pkg;

   // ----------------------------------------------------------------
   // Bus map
   // ----------------------------------------------------------------
   localparam int unsigned DECODE_W = 12;
   localparam logic [DECODE_W-1:0] CTRL_OFFSET = 12'h000;
   localparam logic [DECODE_W-1:0] STATUS_OFFSET = 12'h004;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // ----------------------------------------------------------------
   // Control register layout
   // ----------------------------------------------------------------
   localparam int unsigned BIT_DIV_BYPASS = 0;
   localparam int unsigned BIT_MAIN_EXT = 1;
   localparam int unsigned BIT_SUB_EXT = 2;
   localparam int unsigned BIT_PART_FIX = 3;
   localparam int unsigned BIT_FIX_ZERO = 4;
   localparam int unsigned BIT_PRESC_INIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] KEY_PATTERN = 8'h55;
   localparam logic [7:0] UPPER_MASK = 8'hF8;

   // ----------------------------------------------------------------
   // Status register layout
   // ----------------------------------------------------------------
   localparam int unsigned STAT_ARMED = 0;
   localparam int unsigned STAT_SEQ_ERR = 1;
   localparam int unsigned STAT_CNT_LSB = 8;

   // ----------------------------------------------------------------
   // Counts
   // ----------------------------------------------------------------
   localparam int unsigned PRESC_W_DEFAULT = 8;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b01,
      KEY_ARMED = 2'b10
   } key_state_t;

   typedef struct packed {
      logic fix_zero;
      logic part_fix;
      logic sub_ext;
      logic main_ext;
      logic div_bypass;
   } clk_cfg_t;

   typedef struct packed {
      logic main_osc_enable;
      logic sub_osc_enable;
      logic main_stop_wdt_wait;
      logic sub_stop_wdt_wait;
      logic sub_oscillator_shared_pin_gpio;
   } osc_steer_t;

endpackage : osc_ctrl_pkg

// ---- rtl/clock_prescaler.sv ----
// Clock prescaler: halves or passes the main clock as an enable and counts its ticks
`timescale 1ns/1ps
module clock_prescaler #(
   parameter int unsigned CNT_W = osc_ctrl_pkg::PRESC_W_DEFAULT
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic div_bypass,
   input wire logic init,
   // Results
   output logic main_clk_en,
   output logic [CNT_W-1:0] count
);
   import osc_ctrl_pkg::*;

   typedef struct packed {
      logic phase;
      logic en;
      logic [CNT_W-1:0] count;
   } presc_state_t;

   presc_state_t state_reg;
   presc_state_t state_next;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (init) begin
         // Restart from a known phase so both rates line up after init
         state_next.phase = 1'b0;
         state_next.en = 1'b0;
         state_next.count = '0;
      end else begin
         state_next.phase = ~state_reg.phase;
         state_next.en = div_bypass | state_reg.phase;
         if (state_reg.en) begin
            state_next.count = state_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign main_clk_en = state_reg.en;
   assign count = state_reg.count;

endmodule : clock_prescaler

// ---- rtl/osc_ctrl_top.sv ----
// Oscillator control register with keyed update, AHB-Lite slave and prescaler
//
// Overview of operation
// RULE1 - bit0 zero halves main clock, one passes
// RULE2 - bit1 picks external main clock, skips wait
// RULE3 - bit2 picks external sub clock, frees pin
// RULE4 - writing one to bit7 initialises prescaler; here only an unkeyed write does, a write while armed is dropped
// RULE5 - update needs key write then data write
// RULE6 - bit3 resets per part type, software clears
// RULE7 - software keeps bit4 zero except key write
// RULE8 - bits 5 and 6 ignore writes; here a keyed write with either set is dropped and flags a sequence error, except the key byte, which re-arms
`timescale 1ns/1ps
module osc_ctrl_top #(
   parameter int unsigned PRESC_W = osc_ctrl_pkg::PRESC_W_DEFAULT
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   // Part type strap, high on programmable parts
   input wire logic otp_part_strap,
   // Oscillator and pin steering
   output osc_ctrl_pkg::clk_cfg_t clk_cfg,
   output osc_ctrl_pkg::osc_steer_t osc_steer,
   // Prescaler
   output logic prescaler_init,
   output logic main_clk_en,
   output logic [PRESC_W-1:0] prescaler_count
);
   import osc_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      key_state_t key;
      clk_cfg_t cfg;
      logic seq_error;
      logic [2:0] strap_sync;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic dp_valid;
      logic dp_write;
      logic dp_ctrl;
      logic dp_status;
      logic rd_wait;
      logic ready;
      logic [31:0] rdata;
      logic presc_init;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;

   logic [PRESC_W-1:0] presc_count;
   logic presc_en;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_hit(input logic [31:0] addr, input logic [DECODE_W-1:0] offset);
      addr_hit = (addr[DECODE_W-1:2] == offset[DECODE_W-1:2]);
   endfunction : addr_hit

   // Bits 5 and 6 and the trigger bit always read back as zero
   function automatic logic [7:0] ctrl_view(input clk_cfg_t cfg);
      logic [7:0] v;
      v = 8'h00;
      v[BIT_DIV_BYPASS] = cfg.div_bypass;
      v[BIT_MAIN_EXT] = cfg.main_ext;
      v[BIT_SUB_EXT] = cfg.sub_ext;
      v[BIT_PART_FIX] = cfg.part_fix;
      v[BIT_FIX_ZERO] = cfg.fix_zero;
      ctrl_view = v;
   endfunction : ctrl_view

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   clock_prescaler #(
      .CNT_W(PRESC_W)
   ) u_prescaler (
      .hclk(hclk),
      .hresetn(hresetn),
      .div_bypass(state_reg.cfg.div_bypass), // RULE1
      .init(state_reg.presc_init), // RULE4
      .main_clk_en(presc_en),
      .count(presc_count)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic accept;
   logic dp_done;
   logic [7:0] wbyte;
   logic [31:0] status_word;

   always_comb begin
      state_next = state_reg;
      accept = hsel && htrans[1] && hready;
      dp_done = state_reg.dp_valid && state_reg.ready;
      wbyte = hwdata[7:0];
      status_word = 32'h0000_0000;
      status_word[STAT_ARMED] = (state_reg.key == KEY_ARMED);
      status_word[STAT_SEQ_ERR] = state_reg.seq_error;
      status_word[STAT_CNT_LSB +: PRESC_W] = presc_count;

      // Trigger bit is a one-cycle pulse, never stored
      state_next.presc_init = 1'b0;

      // Strap passes three flops; the count runs from release, and capture waits for the last two to agree
      state_next.strap_sync = {state_reg.strap_sync[1:0], otp_part_strap};
      if (state_reg.strap_cnt != STRAP_SETTLE) begin
         state_next.strap_cnt = state_reg.strap_cnt + 1'b1;
      end

      // Caught once after release so reset itself stays constant
      if (!state_reg.strap_done && state_reg.strap_cnt == STRAP_SETTLE
          && state_reg.strap_sync[1] == state_reg.strap_sync[2]) begin
         state_next.strap_done = 1'b1;
         state_next.cfg.part_fix = state_reg.strap_sync[2]; // RULE6
      end

      // Address phase
      if (hready) begin
         state_next.dp_valid = accept;
         state_next.dp_write = hwrite;
         state_next.dp_ctrl = addr_hit(haddr, CTRL_OFFSET);
         state_next.dp_status = addr_hit(haddr, STATUS_OFFSET);
      end

      // Reads take one wait state so the data reflects the write just before
      if (accept && !hwrite) begin
         state_next.ready = 1'b0;
         state_next.rd_wait = 1'b1;
      end
      if (state_reg.rd_wait) begin
         state_next.rd_wait = 1'b0;
         state_next.ready = 1'b1;
         if (state_reg.dp_ctrl) begin
            state_next.rdata = {24'h00_0000, ctrl_view(state_reg.cfg)}; // RULE8
         end else if (state_reg.dp_status) begin
            state_next.rdata = status_word;
         end else begin
            state_next.rdata = 32'h0000_0000;
         end
      end

      // Data phase of a finished transfer
      if (dp_done) begin
         if (state_reg.dp_write && state_reg.dp_ctrl) begin
            case (state_reg.key)
               KEY_IDLE: begin
                  if (wbyte == KEY_PATTERN) begin
                     // Key byte carries bit4 high but is not stored
                     state_next.key = KEY_ARMED; // RULE5 RULE7
                  end else begin
                     // Unkeyed write reaches only bits 3, 4 and the trigger
                     state_next.cfg.part_fix = wbyte[BIT_PART_FIX]; // RULE6
                     state_next.cfg.fix_zero = wbyte[BIT_FIX_ZERO]; // RULE7
                     state_next.presc_init = wbyte[BIT_PRESC_INIT]; // RULE4
                  end
               end
               KEY_ARMED: begin
                  if ((wbyte & UPPER_MASK) == 8'h00) begin
                     state_next.cfg.div_bypass = wbyte[BIT_DIV_BYPASS]; // RULE1
                     state_next.cfg.main_ext = wbyte[BIT_MAIN_EXT]; // RULE2
                     state_next.cfg.sub_ext = wbyte[BIT_SUB_EXT]; // RULE3
                     state_next.cfg.part_fix = 1'b0; // RULE6
                     state_next.cfg.fix_zero = 1'b0; // RULE7
                     state_next.key = KEY_IDLE; // RULE5
                  end else if (wbyte == KEY_PATTERN) begin
                     state_next.key = KEY_ARMED; // RULE5
                  end else begin
                     state_next.key = KEY_IDLE; // RULE5
                     state_next.seq_error = 1'b1;
                  end
               end
               default: begin
                  state_next.key = KEY_IDLE;
               end
            endcase
         end else begin
            if (state_reg.dp_write && state_reg.dp_status && hwdata[STAT_SEQ_ERR]) begin
               state_next.seq_error = 1'b0;
            end
            // Any other transfer breaks the keyed pair; the set beats the clear
            if (state_reg.key == KEY_ARMED) begin
               state_next.key = KEY_IDLE; // RULE5
               state_next.seq_error = 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg.key <= KEY_IDLE;
         state_reg.cfg <= clk_cfg_t'(CTRL_RESET[4:0]);
         state_reg.seq_error <= 1'b0;
         state_reg.strap_sync <= 3'h0;
         state_reg.strap_cnt <= 2'h0;
         state_reg.strap_done <= 1'b0;
         state_reg.dp_valid <= 1'b0;
         state_reg.dp_write <= 1'b0;
         state_reg.dp_ctrl <= 1'b0;
         state_reg.dp_status <= 1'b0;
         state_reg.rd_wait <= 1'b0;
         state_reg.ready <= 1'b1;
         state_reg.rdata <= 32'h0000_0000;
         state_reg.presc_init <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = state_reg.rdata;
   assign hreadyout = state_reg.ready;
   assign hresp = HRESP_OKAY;

   assign clk_cfg = state_reg.cfg;
   assign osc_steer.main_osc_enable = ~state_reg.cfg.main_ext; // RULE2
   assign osc_steer.main_stop_wdt_wait = ~state_reg.cfg.main_ext; // RULE2
   assign osc_steer.sub_osc_enable = ~state_reg.cfg.sub_ext; // RULE3
   assign osc_steer.sub_stop_wdt_wait = ~state_reg.cfg.sub_ext; // RULE3
   assign osc_steer.sub_oscillator_shared_pin_gpio = state_reg.cfg.sub_ext; // RULE3

   assign prescaler_init = state_reg.presc_init; // RULE4
   assign main_clk_en = presc_en; // RULE1
   assign prescaler_count = presc_count;

endmodule : osc_ctrl_top
